// *** rlfs_master_model.sv ***
// Far-side model: master mode, bus health, unit errors and received bytes.
// Assumes its task is called just after a clock edge.
`timescale 1ns/1ns
module rlfs_master_model (
   output logic        o_run,
   output logic        o_fatal,
   output logic        o_bus_ok,
   output logic [1:0]  o_unit_err,
   output logic [15:0] o_rx_data,
   output logic [1:0]  o_rx_vld
);
   task automatic put(input logic r, f, b, input logic [1:0] e, input logic [15:0] d,
                      input logic [1:0] v);
      o_run = r;
      o_fatal = f;
      o_bus_ok = b;
      o_unit_err = e;
      o_rx_data = d;
      o_rx_vld = v;
   endtask
   initial begin
      put(1'b1, 1'b0, 1'b1, 2'h0, 16'h0000, 2'h0);
   end
endmodule // rlfs_master_model

// *** rlfs_pkg.sv ***
// Package for the remote I/O link fault supervisor: codes, bit positions, reset values.
// Assumes one system clock; all inputs are synchronous to it.
package rlfs_pkg;
   localparam logic [7:0] RLFS_POLICY_HALT  = 8'h55;
   localparam logic [7:0] RLFS_POLICY_RST   = 8'h00;
   localparam int         RLFS_UNIT1_BIT    = 0;
   localparam int         RLFS_UNIT0_BIT    = 1;
   localparam logic [1:0] RLFS_FLAGS_RST    = 2'h0;
   localparam logic       RLFS_LINK_BAD_RST = 1'h1;
   localparam int         RLFS_BYTE_W       = 8;
   localparam int         RLFS_IO_BYTES     = 2;

   typedef enum logic [2:0] {
      RLFS_R_IDLE = 3'b001,
      RLFS_R_HIGH = 3'b010,
      RLFS_R_DONE = 3'b100
   } rlfs_rst_seq_t;
endpackage

// *** rlfs_restart_det.sv ***
// Restart sequence detector for one master unit: high, then low on the restart flag.
// Assumes the flag is sampled once per scan via i_scan.
`timescale 1ns/1ns
module rlfs_restart_det
   import rlfs_pkg::*;
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_scan,
   input  wire logic i_flag,
   input  wire logic i_fault,
   output logic      o_restart
);
   typedef struct packed {
      rlfs_rst_seq_t st;
      logic          pulse;
   } rlfs_det_state_t;

   rlfs_det_state_t s_reg;
   rlfs_det_state_t s_next;

   always_comb begin
      s_next       = s_reg;
      s_next.pulse = 1'b0;
      if (i_scan) begin
         case (s_reg.st)
            RLFS_R_IDLE: begin
               // Rising edge only counts once the fault is gone
               if (i_flag && !i_fault) s_next.st = RLFS_R_HIGH;
            end
            RLFS_R_HIGH: begin
               if (!i_flag) begin
                  s_next.st    = RLFS_R_IDLE;
                  s_next.pulse = 1'b1;
               end
            end
            default: s_next.st = RLFS_R_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '{st: RLFS_R_IDLE, pulse: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_restart = s_reg.pulse;

   property p_restart_needs_high;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_restart |-> ($past(s_reg.st) == RLFS_R_HIGH) && !$past(i_flag);
   endproperty
   a_restart_needs_high: assert property (p_restart_needs_high)
      else $error("Restart pulse without high then low flag");
endmodule // rlfs_restart_det

// *** rlfs_top.sv ***
// Remote I/O link fault supervisor of a slave controller.
// Assumes one clock, synchronous inputs, and a scan strobe from the controller.
`timescale 1ns/1ns
module rlfs_top
   import rlfs_pkg::*;
#(
   parameter int IO_BYTES = RLFS_IO_BYTES
)
(
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_scan,
   input  wire logic                          i_master_run,
   input  wire logic                          i_master_fatal,
   input  wire logic                          i_bus_ok,
   input  wire logic [1:0]                    i_unit_err,
   input  wire logic                          i_restart_we,
   input  wire logic [1:0]                    i_restart_wdata,
   input  wire logic                          i_policy_we,
   input  wire logic [7:0]                    i_policy_wdata,
   input  wire logic [IO_BYTES*RLFS_BYTE_W-1:0] i_rx_data,
   input  wire logic [IO_BYTES-1:0]           i_rx_byte_vld,
   output logic [1:0]                         o_unit_err_flags,
   output logic [1:0]                         o_restart_flags,
   output logic                               o_link_status,
   output logic [7:0]                         o_stop_policy,
   output logic                               o_halted,
   output logic [IO_BYTES*RLFS_BYTE_W-1:0]    o_io_image
);
   // Refused at elaboration: an image with no byte lanes cannot be refreshed
   generate
      if (IO_BYTES < 1) begin : g_bad_io_bytes
         $error("IO_BYTES must be at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [1:0]                      err;
      logic [1:0]                      rst_flag;
      logic                            link_bad;
      logic [7:0]                      policy;
      logic                            halted;
      logic [IO_BYTES*RLFS_BYTE_W-1:0] image;
   } rlfs_state_t;

   rlfs_state_t s_reg;
   rlfs_state_t s_next;
   logic [1:0]  restart_pulse;
   logic        link_bad_now;

   assign link_bad_now = !i_master_run || i_master_fatal || !i_bus_ok;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_unit
         rlfs_restart_det rlfs_restart_det_i (
            .i_clk_sys (i_clk_sys),
            .i_rst_n   (i_rst_n),
            .i_scan    (i_scan),
            .i_flag    (s_reg.rst_flag[g]),
            .i_fault   (i_unit_err[g] || link_bad_now),
            .o_restart (restart_pulse[g])
         );
      end
   endgenerate

   always_comb begin
      s_next          = s_reg;
      s_next.err      = i_unit_err;
      s_next.link_bad = link_bad_now;
      if (i_restart_we) s_next.rst_flag = i_restart_wdata;
      if (i_policy_we) s_next.policy = i_policy_wdata;
      // Halt is sticky; only the restart sequence or power cycle clears it
      if (|restart_pulse) begin
         s_next.halted = 1'b0;
      end
      if (s_reg.policy == RLFS_POLICY_HALT && link_bad_now) begin
         s_next.halted = 1'b1;
      end
      // Whole bytes only, and frozen while halted
      for (int b = 0; b < IO_BYTES; b++) begin
         if (i_rx_byte_vld[b] && !s_reg.halted) begin
            s_next.image[b*RLFS_BYTE_W +: RLFS_BYTE_W] =
               i_rx_data[b*RLFS_BYTE_W +: RLFS_BYTE_W];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg.err      <= RLFS_FLAGS_RST;
         s_reg.rst_flag <= RLFS_FLAGS_RST;
         s_reg.link_bad <= RLFS_LINK_BAD_RST;
         s_reg.policy   <= RLFS_POLICY_RST;
         s_reg.halted   <= 1'b0;
         s_reg.image    <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_unit_err_flags = s_reg.err;
   assign o_restart_flags  = s_reg.rst_flag;
   assign o_link_status    = s_reg.link_bad;
   assign o_stop_policy    = s_reg.policy;
   assign o_halted         = s_reg.halted;
   assign o_io_image       = s_reg.image;

   property p_err_follows;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 o_unit_err_flags == $past(i_unit_err);
   endproperty
   a_err_follows: assert property (p_err_follows)
      else $error("Unit error flags do not follow unit errors");

   property p_restart_write;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_restart_we |=> o_restart_flags == $past(i_restart_wdata);
   endproperty
   a_restart_write: assert property (p_restart_write)
      else $error("Restart flags not written");

   property p_link_good;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_master_run && !i_master_fatal && i_bus_ok) |=> !o_link_status;
   endproperty
   a_link_good: assert property (p_link_good)
      else $error("Link status not 0 on healthy link");

   property p_link_bad;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!i_master_run || i_master_fatal || !i_bus_ok) |=> o_link_status;
   endproperty
   a_link_bad: assert property (p_link_bad)
      else $error("Link status not 1 on link fault");

   property p_halt_on_policy;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_stop_policy == RLFS_POLICY_HALT && !i_bus_ok) |=> o_halted;
   endproperty
   a_halt_on_policy: assert property (p_halt_on_policy)
      else $error("No halt under stop policy");

   property p_no_halt_other;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!o_halted && o_stop_policy != RLFS_POLICY_HALT) |=> !o_halted;
   endproperty
   a_no_halt_other: assert property (p_no_halt_other)
      else $error("Halted though policy says continue");

   sequence s_halt_release;
      o_halted ##1 !o_halted;
   endsequence
   property p_release_cause;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_halt_release |-> $past(|restart_pulse);
   endproperty
   a_release_cause: assert property (p_release_cause)
      else $error("Halt released without restart sequence");

   property p_frozen;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_halted |=> $stable(o_io_image);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("Image changed while halted");

   property p_halt_on_master;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_stop_policy == RLFS_POLICY_HALT && (!i_master_run || i_master_fatal)) |=> o_halted;
   endproperty
   a_halt_on_master: assert property (p_halt_on_master)
      else $error("No halt on master stop under stop policy");

   property p_policy_write;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_policy_we |=> o_stop_policy == $past(i_policy_wdata);
   endproperty
   a_policy_write: assert property (p_policy_write)
      else $error("Stop policy not written");

   property p_restart_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_restart_we |=> $stable(o_restart_flags);
   endproperty
   a_restart_hold: assert property (p_restart_hold)
      else $error("Restart flags changed without a write");

   // Halt is sticky until a restart pulse, and a standing link fault under the halt policy wins over the pulse
   property p_halt_stays;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_halted && !(|restart_pulse)) |=> o_halted;
   endproperty
   a_halt_stays: assert property (p_halt_stays)
      else $error("Halt dropped without restart");

   property p_restart_releases;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (|restart_pulse && !(o_stop_policy == RLFS_POLICY_HALT && link_bad_now)) |=> !o_halted;
   endproperty
   a_restart_releases: assert property (p_restart_releases)
      else $error("Restart pulse did not release halt");

   // One load and one hold check per byte lane, so a torn byte shows up
   generate
      for (g = 0; g < IO_BYTES; g++) begin : g_byte_chk
         property p_byte_load;
            @(posedge i_clk_sys) disable iff (!i_rst_n)
            (!o_halted && i_rx_byte_vld[g]) |=>
               o_io_image[g*RLFS_BYTE_W +: RLFS_BYTE_W] == $past(i_rx_data[g*RLFS_BYTE_W +: RLFS_BYTE_W]);
         endproperty
         a_byte_load: assert property (p_byte_load)
            else $error("Valid byte not loaded into image");

         property p_byte_hold;
            @(posedge i_clk_sys) disable iff (!i_rst_n)
            !i_rx_byte_vld[g] |=> $stable(o_io_image[g*RLFS_BYTE_W +: RLFS_BYTE_W]);
         endproperty
         a_byte_hold: assert property (p_byte_hold)
            else $error("Image byte changed without valid");
      end
   endgenerate
endmodule // rlfs_top

// *** rlfs_top_tb.sv ***
// Self-checking bench for the link fault supervisor.
// Assumes the master model drives all far-side inputs.
`timescale 1ns/1ns
module rlfs_top_tb;
   import rlfs_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, scan = 1'b0, r_we = 1'b0, p_we = 1'b0;
   logic        run, fatal, ok, lnk, hlt;
   logic [1:0]  uerr, vld, eflg, rflg, r_wd = 2'h0;
   logic [7:0]  pol, p_wd = 8'h00;
   logic [15:0] rx, img;
   int          fails = 0, checks_done = 0;
   always #5 clk = ~clk;
   rlfs_master_model rlfs_master_model_i (.o_run(run), .o_fatal(fatal), .o_bus_ok(ok),
      .o_unit_err(uerr), .o_rx_data(rx), .o_rx_vld(vld));
   rlfs_top rlfs_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scan(scan), .i_master_run(run),
      .i_master_fatal(fatal), .i_bus_ok(ok), .i_unit_err(uerr), .i_restart_we(r_we),
      .i_restart_wdata(r_wd), .i_policy_we(p_we), .i_policy_wdata(p_wd), .i_rx_data(rx),
      .i_rx_byte_vld(vld), .o_unit_err_flags(eflg), .o_restart_flags(rflg),
      .o_link_status(lnk), .o_stop_policy(pol), .o_halted(hlt), .o_io_image(img));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic r, input logic [7:0] d);
      r_we = r;
      p_we = ~r;
      r_wd = d[1:0];
      p_wd = d;
      cyc(1);
      r_we = 1'b0;
      p_we = 1'b0;
      chk(r ? 16'(rflg) : 16'(pol), r ? 16'(d[1:0]) : 16'(d));
   endtask
   task automatic pscan();
      scan = 1'b1;
      cyc(1);
      scan = 1'b0;
   endtask
   task automatic wait_h(input logic e);
      for (int i = 0; i < 8 && hlt !== e; i++) cyc(1);
      chk(16'(hlt), 16'(e));
   endtask
   task automatic t_link();
      logic [2:0] c [4] = '{3'b101, 3'b001, 3'b111, 3'b100};
      for (int i = 0; i < 4; i++) begin
         rlfs_master_model_i.put(c[i][2], c[i][1], c[i][0], 2'(i), 16'h0000, 2'h0);
         cyc(1);
         chk(16'(lnk), 16'(i != 0));
         chk(16'(eflg), 16'(i));
      end
      $display("test link done");
   endtask
   task automatic t_cont();
      wr(1'b0, 8'h54);
      rlfs_master_model_i.put(1'b0, 1'b1, 1'b0, 2'h3, 16'h1234, 2'h3);
      cyc(4);
      chk(16'(hlt), 16'h0);
      chk(img, 16'h1234);
      rlfs_master_model_i.put(1'b0, 1'b1, 1'b0, 2'h3, 16'hbeef, 2'h1);
      cyc(1);
      chk(img, 16'h12ef);
      $display("test continue done");
   endtask
   task automatic t_halt();
      wr(1'b0, RLFS_POLICY_HALT);
      wait_h(1'b1);
      rlfs_master_model_i.put(1'b1, 1'b0, 1'b0, 2'h1, 16'h5555, 2'h3);
      cyc(2);
      chk(img, 16'h12ef);
      // Restart attempt while the fault stands must be ignored
      wr(1'b1, 8'h02);
      pscan();
      wr(1'b1, 8'h00);
      pscan();
      cyc(3);
      chk(16'(hlt), 16'h1);
      rlfs_master_model_i.put(1'b1, 1'b0, 1'b1, 2'h0, 16'h5555, 2'h0);
      cyc(1);
      wr(1'b1, 8'h01);
      pscan();
      wr(1'b1, 8'h00);
      pscan();
      wait_h(1'b0);
      $display("test halt done");
   endtask
   task automatic t_repower();
      // Master drops to edit mode under the halt policy left by the last test
      rlfs_master_model_i.put(1'b0, 1'b0, 1'b1, 2'h0, 16'h0000, 2'h0);
      wait_h(1'b1);
      rlfs_master_model_i.put(1'b1, 1'b0, 1'b1, 2'h0, 16'ha5c3, 2'h3);
      rst_n = 1'b0;
      cyc(2);
      chk(16'(hlt), 16'h0);
      chk(16'(lnk), 16'(RLFS_LINK_BAD_RST));
      chk(16'(pol), 16'(RLFS_POLICY_RST));
      rst_n = 1'b1;
      cyc(1);
      chk(16'(lnk), 16'h0);
      chk(img, 16'ha5c3);
      $display("test repower done");
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      close_out();
   end
   initial begin
      cyc(20);
      chk(16'(lnk), 16'(RLFS_LINK_BAD_RST));
      chk(16'(pol), 16'(RLFS_POLICY_RST));
      chk(16'(hlt), 16'h0);
      rst_n = 1'b1;
      t_link();
      t_cont();
      t_halt();
      t_repower();
      close_out();
   end
endmodule // rlfs_top_tb
